// file: logic/spi_buf_map.vh
// Offsets, field positions, reset values and codes of the SPI buffer block.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
`ifndef SPI_BUF_MAP_VH
`define SPI_BUF_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_STATUS 8'h10
`define OFF_LEVEL 8'h14
`define OFF_IE 8'h18
`define OFF_THRESH 8'h1c
`define OFF_TXDATA 8'h20
`define OFF_RXDATA 8'h24
`define OFF_CLEAR 8'h2c
// ----------------------------------------
// Status and enable bit positions
// ----------------------------------------
`define BIT_RX_REQ 14
`define BIT_RX_EMPTY 13
`define BIT_RX_FULL 12
`define BIT_TX_REQ 10
`define BIT_TX_EMPTY 9
`define BIT_TX_FULL 8
`define BIT_PROG_ERR 4
`define BIT_RX_UNF 3
`define BIT_TX_OVF 2
`define BIT_DMA_DONE 1
`define BIT_XFER_DONE 0
`define STICKY_W 5
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define IE_RESET 32'h00002000
`define IE_MASK 32'h0000771f
`define THRESH_RESET 32'h00000000
// ----------------------------------------
// Bus answers and sizes
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_BYTE 4'h1
`define STRB_HALF 4'h3
`define STRB_WORD 4'hf
`define RD_BYTES 3'h4
`define LAST_BIT 3'h7
`define TX_IDLE 8'hff
`endif

// file: logic/spi_master_buffer_status_irq.v
// FIFO levels, thresholds, interrupts and transmit/receive data ports of an SPI master.
// Assumes an AXI4-Lite master on aclk and a link clock sampled as a plain input.
//
// What this block does
// - Receive byte level in level register top
// - Transmit byte level in level register bottom
// - Receive request, empty, full interrupt enables
// - Transmit request, empty, full interrupt enables
// - Programming, underflow, overflow error interrupt enables
// - DMA-done and transfer-done interrupt enables
// - Only receive-empty enable set after reset
// - Receive level at or above threshold requests
// - Transmit level at or below threshold requests
// - Transmit write pushes one, two, four bytes
// - Write to full transmit FIFO flags overflow
// - Transmit write raises level by bytes written
// - Receive data read pops bytes, lowers level
// - Short receive read flags underflow, write-one clears
// - Transmit request status follows threshold compare
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`include "spi_buf_map.vh"
module spi_master_buffer_status_irq #(
   parameter AW = 4,
   parameter ADDR_W = 8
) (
   // Clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire ce,
   // AXI4-Lite write
   input wire awvalid,
   output wire awready,
   input wire [ADDR_W-1:0] awaddr,
   input wire [2:0] awprot,
   input wire wvalid,
   output wire wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   output wire bvalid,
   input wire bready,
   output wire [1:0] bresp,
   // AXI4-Lite read
   input wire arvalid,
   output wire arready,
   input wire [ADDR_W-1:0] araddr,
   input wire [2:0] arprot,
   output wire rvalid,
   input wire rready,
   output wire [31:0] rdata,
   output wire [1:0] rresp,
   // Serial link
   input wire link_clk,
   input wire miso,
   output wire mosi,
   // Events from the transfer engine
   input wire xfer_done,
   input wire dma_done,
   input wire prog_error,
   // Interrupt
   output wire irq
);
   localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [7:0] tx_mem [0:(1<<AW)-1];
   reg [7:0] rx_mem [0:(1<<AW)-1];
   reg [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   reg [AW:0] tx_cnt_q, rx_cnt_q;
   reg [31:0] ie_q, thr_q;
   reg [`STICKY_W-1:0] sticky_q;
   reg aw_q, w_q, bvalid_q, rvalid_q, irq_q, mosi_q;
   reg [ADDR_W-1:0] waddr_q;
   reg [31:0] wdata_q, rdata_q;
   reg [3:0] wstrb_q;
   reg [1:0] bresp_q, rresp_q;
   reg link_s1_q, link_s2_q, link_s3_q, miso_s1_q, miso_s2_q;
   reg [2:0] bit_cnt_q;
   reg [7:0] rx_sh_q, tx_sh_q;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [2:0] nbytes;
      input [3:0] strb;
      begin
         case (strb)
            `STRB_BYTE: nbytes = 3'h1;
            `STRB_HALF: nbytes = 3'h2;
            `STRB_WORD: nbytes = 3'h4;
            default: nbytes = 3'h0;
         endcase
      end
   endfunction
   function [15:0] lvl16;
      input [AW:0] c;
      begin
         lvl16 = {{(15-AW){1'b0}}, c};
      end
   endfunction
   // ----------------------------------------
   // Combinational decode
   // ----------------------------------------
   wire wr_go = aw_q & w_q & ~bvalid_q;
   wire rd_go = arvalid & ~rvalid_q;
   wire [2:0] push_n = nbytes(wstrb_q);
   wire [AW:0] push_w = {{(AW-2){1'b0}}, push_n};
   wire tx_wr = wr_go && (waddr_q == `OFF_TXDATA);
   wire tx_room = (DEPTH - tx_cnt_q) >= push_w;
   wire tx_push = tx_wr && (push_n != 3'h0) && tx_room;
   wire tx_ovf = tx_wr && (push_n != 3'h0) && !tx_room;
   wire link_rise = link_s2_q & ~link_s3_q;
   wire link_fall = ~link_s2_q & link_s3_q;
   wire byte_end = link_rise && (bit_cnt_q == `LAST_BIT);
   wire tx_pop = byte_end && (tx_cnt_q != {(AW+1){1'b0}});
   wire rx_push = byte_end && (rx_cnt_q != DEPTH);
   wire rx_rd = rd_go && (araddr == `OFF_RXDATA);
   wire rx_short = rx_cnt_q < {{(AW-2){1'b0}}, `RD_BYTES};
   wire [2:0] pop_n = rx_short ? rx_cnt_q[2:0] : `RD_BYTES;
   wire [AW:0] pop_w = rx_rd ? {{(AW-2){1'b0}}, pop_n} : {(AW+1){1'b0}};
   wire rx_unf = rx_rd && rx_short;
   wire [15:0] rx_lvl = lvl16(rx_cnt_q);
   wire [15:0] tx_lvl = lvl16(tx_cnt_q);
   wire rx_req = (thr_q[31:16] != 16'h0) && (rx_lvl >= thr_q[31:16]);
   wire tx_cmp = tx_lvl <= thr_q[15:0];
   wire tx_req = (thr_q[15:0] != 16'h0) && tx_cmp;
   wire rx_empty = rx_cnt_q == {(AW+1){1'b0}};
   wire rx_full = rx_cnt_q == DEPTH;
   wire tx_empty = tx_cnt_q == {(AW+1){1'b0}};
   wire tx_full = tx_cnt_q == DEPTH;
   wire clr_wr = wr_go && (waddr_q == `OFF_CLEAR);
   reg [31:0] status;
   reg [31:0] src;
   reg [31:0] rd_word;
   reg [31:0] rx_word;
   reg [`STICKY_W-1:0] set_v;
   reg rd_err;
   integer i;
   // Separate loop index for the clocked process, so no variable has two drivers
   integer j;
   always @*
   begin
      set_v = {`STICKY_W{1'b0}};
      set_v[`BIT_PROG_ERR] = prog_error;
      set_v[`BIT_RX_UNF] = rx_unf;
      set_v[`BIT_TX_OVF] = tx_ovf;
      set_v[`BIT_DMA_DONE] = dma_done;
      set_v[`BIT_XFER_DONE] = xfer_done;
      status = {{(32-`STICKY_W){1'b0}}, sticky_q};
      status[`BIT_RX_REQ] = rx_req;
      status[`BIT_RX_EMPTY] = rx_empty;
      status[`BIT_RX_FULL] = rx_full;
      status[`BIT_TX_REQ] = tx_cmp;
      status[`BIT_TX_EMPTY] = tx_empty;
      status[`BIT_TX_FULL] = tx_full;
      // Interrupt source uses the gated compare so a zero threshold stays quiet
      src = status;
      src[`BIT_TX_REQ] = tx_req;
      rx_word = 32'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         if (i < pop_n)
            rx_word[8*i +: 8] = rx_mem[rx_rp_q + i[AW-1:0]];
      end
      rd_err = 1'b0;
      case (araddr)
         `OFF_STATUS: rd_word = status;
         `OFF_LEVEL: rd_word = {rx_lvl, tx_lvl};
         `OFF_IE: rd_word = ie_q;
         `OFF_THRESH: rd_word = thr_q;
         `OFF_RXDATA: rd_word = rx_word;
         `OFF_TXDATA: rd_word = 32'h0;
         `OFF_CLEAR: rd_word = 32'h0;
         default:
         begin
            rd_word = 32'h0;
            rd_err = 1'b1;
         end
      endcase
   end
   // ----------------------------------------
   // Bus handshakes
   // ----------------------------------------
   assign awready = ~aw_q;
   assign wready = ~w_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = ~rvalid_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign mosi = mosi_q;
   assign irq = irq_q;
   // ----------------------------------------
   // Registers, FIFOs and link
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_wp_q <= {AW{1'b0}};
         tx_rp_q <= {AW{1'b0}};
         rx_wp_q <= {AW{1'b0}};
         rx_rp_q <= {AW{1'b0}};
         tx_cnt_q <= {(AW+1){1'b0}};
         rx_cnt_q <= {(AW+1){1'b0}};
         ie_q <= `IE_RESET;
         thr_q <= `THRESH_RESET;
         sticky_q <= {`STICKY_W{1'b0}};
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         irq_q <= 1'b0;
         mosi_q <= 1'b1;
         waddr_q <= {ADDR_W{1'b0}};
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bresp_q <= `RESP_OKAY;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0;
         link_s1_q <= 1'b0;
         link_s2_q <= 1'b0;
         link_s3_q <= 1'b0;
         miso_s1_q <= 1'b0;
         miso_s2_q <= 1'b0;
         bit_cnt_q <= 3'h0;
         rx_sh_q <= 8'h0;
         tx_sh_q <= `TX_IDLE;
      end
      else if (ce)
      begin
         // Write address and data taken in either order
         if (awvalid && !aw_q)
         begin
            aw_q <= 1'b1;
            waddr_q <= awaddr;
         end
         if (wvalid && !w_q)
         begin
            w_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= `RESP_OKAY;
            case (waddr_q)
               `OFF_IE: ie_q <= wdata_q & `IE_MASK;
               `OFF_THRESH: thr_q <= wdata_q;
               `OFF_TXDATA:
                  if (push_n == 3'h0)
                     bresp_q <= `RESP_SLVERR;
               `OFF_STATUS, `OFF_LEVEL, `OFF_RXDATA, `OFF_CLEAR: bresp_q <= `RESP_OKAY;
               default: bresp_q <= `RESP_SLVERR;
            endcase
         end
         else if (bvalid_q && bready)
            bvalid_q <= 1'b0;
         if (rd_go)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
         end
         else if (rvalid_q && rready)
            rvalid_q <= 1'b0;
         // Low bytes only; upper lanes of a short write are ignored
         if (tx_push)
         begin
            for (j = 0; j < 4; j = j + 1)
            begin
               if (j < push_n)
                  tx_mem[tx_wp_q + j[AW-1:0]] <= wdata_q[8*j +: 8];
            end
            tx_wp_q <= tx_wp_q + push_w[AW-1:0];
         end
         tx_cnt_q <= tx_cnt_q + (tx_push ? push_w : {(AW+1){1'b0}})
                     - {{AW{1'b0}}, tx_pop};
         if (rx_rd)
            rx_rp_q <= rx_rp_q + pop_w[AW-1:0];
         rx_cnt_q <= rx_cnt_q + {{AW{1'b0}}, rx_push} - pop_w;
         // Set wins over a same-cycle clear
         sticky_q <= (sticky_q & ~(clr_wr ? wdata_q[`STICKY_W-1:0] : {`STICKY_W{1'b0}}))
                     | set_v;
         irq_q <= |(src & ie_q);
         // Link side: two-stage sync, edges seen on the second stage
         link_s1_q <= link_clk;
         link_s2_q <= link_s1_q;
         link_s3_q <= link_s2_q;
         miso_s1_q <= miso;
         miso_s2_q <= miso_s1_q;
         if (link_rise)
         begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q <= {rx_sh_q[6:0], miso_s2_q};
            if (byte_end)
            begin
               // Full receive FIFO drops the byte rather than stall the link
               if (rx_push)
               begin
                  rx_mem[rx_wp_q] <= {rx_sh_q[6:0], miso_s2_q};
                  rx_wp_q <= rx_wp_q + {{(AW-1){1'b0}}, 1'b1};
               end
               if (tx_pop)
               begin
                  tx_sh_q <= tx_mem[tx_rp_q];
                  tx_rp_q <= tx_rp_q + {{(AW-1){1'b0}}, 1'b1};
               end
               else
                  tx_sh_q <= `TX_IDLE;
            end
            else
               tx_sh_q <= {tx_sh_q[6:0], 1'b1};
         end
         if (link_fall)
            mosi_q <= tx_sh_q[7];
      end
   end
endmodule // spi_master_buffer_status_irq

// file: test/spi_slave_model.sv
// Serial slave at the far side of the link: makes the link clock within frames only.
// Assumes a one-shot run request; each frame is 32 bits, MSB first.
`timescale 1ns/1ns
module spi_slave_model #(
   parameter [7:0] FIRST_BYTE = 8'h5a
) (
   // Frame request
   input wire run,
   // Serial link
   input wire mosi,
   output reg link_clk,
   output reg miso,
   // Bits seen on mosi
   output reg [31:0] seen
);
   integer i;
   initial
   begin
      link_clk = 1'b0;
      miso = 1'b0;
      seen = 32'h0;
      forever
      begin
         wait (run);
         for (i = 31; i >= 0; i = i - 1)
         begin
            miso = ((FIRST_BYTE + 8'h3 - i / 8) >> (i % 8)) & 1;
            #62 link_clk = 1'b1;
            seen = {seen[30:0], mosi};
            #63 link_clk = 1'b0;
         end
         // Released line: inverse of last bit so a stale value is never trusted
         miso = ~miso;
         wait (!run);
      end
   end
endmodule // spi_slave_model

// file: test/spi_buf_properties.sv
// Bus answer and transmit port checks of the SPI buffer block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ns
`include "spi_buf_map.vh"
module spi_buf_properties #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   input wire ce,
   // Register bus
   input wire awvalid,
   input wire awready,
   input wire [ADDR_W-1:0] awaddr,
   input wire wvalid,
   input wire wready,
   input wire [3:0] wstrb,
   input wire bvalid,
   input wire bready,
   input wire [1:0] bresp,
   input wire arvalid,
   input wire arready,
   input wire [ADDR_W-1:0] araddr,
   input wire rvalid,
   input wire rready,
   input wire [31:0] rdata,
   input wire [1:0] rresp
);
   reg [ADDR_W-1:0] wa_q;
   reg [3:0] ws_q;
   wire tx_hit = (wa_q == `OFF_TXDATA);
   wire strb_ok = (ws_q == `STRB_BYTE) || (ws_q == `STRB_HALF) || (ws_q == `STRB_WORD);
   // Address and strobe kept apart: the two channels may be taken in either order
   always @(posedge aclk)
   begin
      if (awvalid && awready)
         wa_q <= awaddr;
      if (wvalid && wready)
         ws_q <= wstrb;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_take;
      arvalid && arready && ce;
   endsequence
   sequence s_wr_take;
      awvalid && awready && wvalid && wready && ce;
   endsequence
   AST_AR_ANSWER: assert property (s_ar_take |=> rvalid)
      else $error("read not answered");
   AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped");
   AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   AST_W_ANSWER: assert property (s_wr_take |-> ##[1:2] bvalid)
      else $error("write not answered");
   AST_TX_READ_ZERO: assert property (arvalid && arready && ce && araddr == `OFF_TXDATA |=> rdata == 32'h0)
      else $error("write port read not zero");
   AST_LVL_READ_OK: assert property (arvalid && arready && ce && araddr == `OFF_LEVEL |=> rresp == `RESP_OKAY)
      else $error("level read refused");
   AST_TX_STRB_OK: assert property ($rose(bvalid) && tx_hit && strb_ok |-> bresp == `RESP_OKAY)
      else $error("sized push refused");
   AST_TX_STRB_BAD: assert property ($rose(bvalid) && tx_hit && !strb_ok |-> bresp == `RESP_SLVERR)
      else $error("odd strobe accepted");
endmodule // spi_buf_properties
bind spi_master_buffer_status_irq spi_buf_properties #(.ADDR_W(ADDR_W)) u_props (.aclk(aclk), .aresetn(aresetn),
   .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wstrb(wstrb),
   .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

// file: test/tb_spi_master_buffer_status_irq.sv
// Self-checking bench of the SPI buffer block: bus tasks, serial slave, answer queue.
// Assumes the register map header and the slave model beside it.
`timescale 1ns/1ns
`include "spi_buf_map.vh"
module tb_spi_master_buffer_status_irq;
   reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, prog_error, dma_done, xfer_done;
   reg ce;
   reg [7:0] awaddr, araddr, b0;
   reg [31:0] wdata, d;
   reg [3:0] wstrb, hs;
   reg [34:0] q[$];
   reg [34:0] e;
   reg fin;
   integer error_cnt, n_tests, seed, cyc;
   wire awready, wready, bvalid, arready, rvalid, link_clk, miso, mosi, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, seen;
   spi_master_buffer_status_irq DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .link_clk(link_clk), .miso(miso), .mosi(mosi), .xfer_done(xfer_done), .dma_done(dma_done),
      .prog_error(prog_error), .irq(irq));
   spi_slave_model u_slave (.run(run), .mosi(mosi), .link_clk(link_clk), .miso(miso), .seen(seen));
   always #5 aclk = ~aclk;
   task automatic cmp(input string nm, input [31:0] ex, input [31:0] got);
   begin
      n_tests = n_tests + 1;
      if (got !== ex)
      begin
         error_cnt = error_cnt + 1;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   end
   endtask
   task results;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // One access; the answer is noted for the watcher
   task acc(input w, input [7:0] a, input [31:0] dt, input [3:0] s, input [1:0] er, input [31:0] ed);
   begin
      @(posedge aclk);
      q.push_back({w, er, ed});
      fin = 1'b0;
      awaddr <= a;
      araddr <= a;
      wdata <= dt;
      wstrb <= s;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (!fin)
      begin
         @(negedge aclk);
         hs = {awready, wready, arready, (bvalid && bready) || (rvalid && rready)};
         @(posedge aclk);
         if (hs[3])
            awvalid <= 1'b0;
         if (hs[2])
            wvalid <= 1'b0;
         if (hs[1])
            arvalid <= 1'b0;
         if (hs[0])
         begin
            bready <= 1'b0;
            rready <= 1'b0;
            fin = 1'b1;
         end
      end
   end
   endtask
   task chk_irq(input x);
   begin
      repeat (3) @(negedge aclk);
      cmp("irq", {31'h0, x}, {31'h0, irq});
   end
   endtask
   always @(negedge aclk)
      if ((bvalid && bready) || (rvalid && rready))
      begin
         e = q.pop_front();
         cmp("resp", {30'h0, e[33:32]}, {30'h0, bvalid ? bresp : rresp});
         if (!e[34])
            cmp("rdata", e[31:0], rdata);
      end
   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         results;
      end
   end
   initial
   begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, prog_error, dma_done, xfer_done} = 11'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      ce = 1'b1;
      {error_cnt, n_tests, cyc} = 0;
      seed = 90;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      acc(0, `OFF_LEVEL, 0, 0, `RESP_OKAY, 32'h0);
      acc(0, `OFF_IE, 0, 0, `RESP_OKAY, `IE_RESET);
      acc(0, `OFF_THRESH, 0, 0, `RESP_OKAY, `THRESH_RESET);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2600);
      acc(0, `OFF_TXDATA, 0, 0, `RESP_OKAY, 32'h0);
      acc(0, 8'h3c, 0, 0, `RESP_SLVERR, 32'h0);
      chk_irq(1);
      acc(1, `OFF_IE, 32'hffffffff, `STRB_WORD, `RESP_OKAY, 0);
      acc(0, `OFF_IE, 0, 0, `RESP_OKAY, `IE_MASK);
      acc(1, `OFF_IE, 32'h0, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(0);
      $display("test reset and enables ended");
      d = $random(seed);
      b0 = d[7:0];
      acc(1, `OFF_TXDATA, {24'h0, d[7:0]}, `STRB_BYTE, `RESP_OKAY, 0);
      acc(1, `OFF_TXDATA, {16'h0, d[15:0]}, `STRB_HALF, `RESP_OKAY, 0);
      acc(1, `OFF_TXDATA, d, `STRB_WORD, `RESP_OKAY, 0);
      acc(1, `OFF_TXDATA, d, 4'h2, `RESP_SLVERR, 0);
      acc(0, `OFF_LEVEL, 0, 0, `RESP_OKAY, 32'h7);
      repeat (3) acc(1, `OFF_TXDATA, $random(seed), `STRB_WORD, `RESP_OKAY, 0);
      acc(1, `OFF_TXDATA, d, `STRB_BYTE, `RESP_OKAY, 0);
      acc(0, `OFF_LEVEL, 0, 0, `RESP_OKAY, 32'h10);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2104);
      acc(1, `OFF_IE, 32'h4, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(1);
      acc(1, `OFF_CLEAR, 32'h4, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(0);
      $display("test transmit fill ended");
      acc(1, `OFF_THRESH, 32'h00020010, `STRB_WORD, `RESP_OKAY, 0);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2500);
      acc(1, `OFF_IE, 32'h4400, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(1);
      run <= 1'b1;
      @(posedge aclk);
      run <= 1'b0;
      // Frame length: 32 link periods of 125 ns
      repeat (420) @(posedge aclk);
      acc(0, `OFF_LEVEL, 0, 0, `RESP_OKAY, 32'h0004000c);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h4400);
      cmp("mosi byte", {24'h0, b0}, {24'h0, seen[23:16]});
      acc(0, `OFF_RXDATA, 0, 0, `RESP_OKAY, 32'h5d5c5b5a);
      acc(0, `OFF_LEVEL, 0, 0, `RESP_OKAY, 32'h0000000c);
      acc(0, `OFF_RXDATA, 0, 0, `RESP_OKAY, 32'h0);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2408);
      acc(1, `OFF_CLEAR, 32'h8, `STRB_WORD, `RESP_OKAY, 0);
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2400);
      $display("test link and receive ended");
      // Events while frozen must leave no trace
      ce <= 1'b0;
      {prog_error, dma_done, xfer_done} <= 3'h7;
      @(posedge aclk);
      ce <= 1'b1;
      {prog_error, dma_done, xfer_done} <= 3'h0;
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2400);
      {prog_error, dma_done, xfer_done} <= 3'h7;
      @(posedge aclk);
      {prog_error, dma_done, xfer_done} <= 3'h0;
      acc(0, `OFF_STATUS, 0, 0, `RESP_OKAY, 32'h2413);
      acc(1, `OFF_IE, 32'h13, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(1);
      acc(1, `OFF_CLEAR, 32'h13, `STRB_WORD, `RESP_OKAY, 0);
      chk_irq(0);
      $display("test events ended");
      results;
   end
endmodule // tb_spi_master_buffer_status_irq
